// ---- rtl/dsip_consts.svh ----
// constants of the dac serial input port
//
// Functional notes
// - three-wire mode: shift serial data input into shift register on each serial clock rising edge
// - load strobe copies shift register into holding latch and updates the converter
// - sixteen bit shift register; overflow bits leave on serial data output
// - one load strobe updates every chained device; chain length unlimited
// - load strobe held high through pull-up selects asynchronous input mode
// - zero code gives range low end, all ones full scale minus one LSB
// - asynchronous word framed by start and stop bit; frame triggers internal latch
`ifndef DSIP_CONSTS_SVH
`define DSIP_CONSTS_SVH
`define DSIP_WORD_BITS  16
`define DSIP_FIFO_DEPTH 16
`define DSIP_OVS_LAST   4'hF
`define DSIP_MID_TICK   4'h7
`define DSIP_LAST_BIT   5'h0F
`define DSIP_MODE_WAIT  2'h3
`endif

// ---- rtl/dsip_pkg.sv ----
// types of the dac serial input port
package dsip_pkg;

  typedef enum logic [1:0] {
    DSIP_RX_IDLE  = 2'b00,
    DSIP_RX_START = 2'b01,
    DSIP_RX_DATA  = 2'b10,
    DSIP_RX_STOP  = 2'b11
  } dsip_rx_e;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic latch;
  } dsip_pins_s;

  typedef struct packed {
    dsip_pins_s  sync1;
    dsip_pins_s  sync2;
    logic        sclk_d;
    logic        latch_d;
    logic [15:0] shift;
    logic [15:0] hold;
    logic        sdout;
    logic        async_mode;
    logic [1:0]  mode_cnt;
    logic        mode_done;
    dsip_rx_e    rx_st;
    logic [3:0]  tick;
    logic [4:0]  bitn;
    logic        pend;
    logic [15:0] pend_word;
  } dsip_state_s;

endpackage

// ---- rtl/dsip_top.sv ----
// dac serial input port: three-wire and framed asynchronous receiver with word fifo
`timescale 1ns/1ps
`include "dsip_consts.svh"

// ----------------------------------------------------------------
// word fifo with registered output stage
// ----------------------------------------------------------------
module dsip_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
    logic                ov;
    logic [W-1:0]        od;
  } fifo_state_s;

  fifo_state_s st_r;
  fifo_state_s st_nxt;
  logic        push;
  logic        pop;

  assign o_in_ready  = (st_r.cnt != CW'(D));
  assign o_out_valid = st_r.ov;
  assign o_out_data  = st_r.od;

  always_comb begin
    st_nxt = st_r;
    push   = i_in_valid && o_in_ready;
    pop    = (st_r.cnt != '0) && (!st_r.ov || i_out_ready);
    if (st_r.ov && i_out_ready) begin
      st_nxt.ov = 1'b0;
    end
    if (pop) begin
      st_nxt.od = st_r.mem[st_r.rp];
      st_nxt.ov = 1'b1;
      st_nxt.rp = (st_r.rp == AW'(D - 1)) ? '0 : st_r.rp + 1'b1;
    end
    if (push) begin
      st_nxt.mem[st_r.wp] = i_in_data;
      st_nxt.wp = (st_r.wp == AW'(D - 1)) ? '0 : st_r.wp + 1'b1;
    end
    case ({push, pop})
      2'b10:   st_nxt.cnt = st_r.cnt + 1'b1;
      2'b01:   st_nxt.cnt = st_r.cnt - 1'b1;
      default: st_nxt.cnt = st_r.cnt;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ----------------------------------------------------------------
// serial input port
// ----------------------------------------------------------------
module dsip_top
  import dsip_pkg::*;
#(
  parameter int WORD_BITS  = `DSIP_WORD_BITS,
  parameter int FIFO_DEPTH = `DSIP_FIFO_DEPTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_sclk,
  input  wire logic        i_sdata,
  input  wire logic        i_latch,
  output logic             o_sdout,
  output logic [15:0]      o_dac_code,
  output logic             o_async_mode,
  output logic             o_word_valid,
  output logic [15:0]      o_word_data,
  input  wire logic        i_word_ready
);
  dsip_state_s st_r;
  dsip_state_s st_nxt;
  dsip_pins_s  pins;
  logic        sclk_rise;
  logic        latch_rise;
  logic        in_ready;
  logic        do_shift;
  logic        do_latch;

  assign pins.sclk  = i_sclk;
  assign pins.sdata = i_sdata;
  assign pins.latch = i_latch;

  // ----------------------------------------------------------------
  // edge detection on synchronised pins
  // ----------------------------------------------------------------
  assign sclk_rise  = st_r.sync2.sclk && !st_r.sclk_d;
  assign latch_rise = st_r.sync2.latch && !st_r.latch_d;

  always_comb begin
    st_nxt         = st_r;
    do_shift       = 1'b0;
    do_latch       = 1'b0;
    st_nxt.sync1   = pins;
    st_nxt.sync2   = st_r.sync1;
    st_nxt.sclk_d  = st_r.sync2.sclk;
    st_nxt.latch_d = st_r.sync2.latch;

    // strap caught a few cycles after release, once the synchroniser holds the pin
    // limitation: read once per reset; a host idling the strobe high reads as async
    if (!st_r.mode_done) begin
      st_nxt.mode_cnt = st_r.mode_cnt + 1'b1;
      if (st_r.mode_cnt == `DSIP_MODE_WAIT) begin
        st_nxt.async_mode = st_r.sync2.latch;
        st_nxt.mode_done  = 1'b1;
      end
    end

    if (st_r.mode_done && !st_r.async_mode) begin
      // three-wire: every rising serial clock edge shifts one bit
      do_shift = sclk_rise;
      // update relies on the host holding the serial clock still meanwhile
      do_latch = latch_rise;
    end else if (st_r.mode_done && sclk_rise) begin
      // asynchronous: serial clock edges are oversample ticks
      st_nxt.tick = st_r.tick + 1'b1;
      case (st_r.rx_st)
        DSIP_RX_IDLE: begin
          st_nxt.tick = '0;
          if (!st_r.sync2.sdata) begin
            st_nxt.rx_st = DSIP_RX_START;
          end
        end
        DSIP_RX_START: begin
          if (st_r.tick == `DSIP_MID_TICK) begin
            st_nxt.tick = '0;
            st_nxt.bitn = '0;
            // a glitch that is high at mid-bit is no start bit
            st_nxt.rx_st = st_r.sync2.sdata ? DSIP_RX_IDLE : DSIP_RX_DATA;
          end
        end
        DSIP_RX_DATA: begin
          if (st_r.tick == `DSIP_OVS_LAST) begin
            do_shift    = 1'b1;
            st_nxt.bitn = st_r.bitn + 1'b1;
            if (st_r.bitn == `DSIP_LAST_BIT) begin
              st_nxt.rx_st = DSIP_RX_STOP;
            end
          end
        end
        DSIP_RX_STOP: begin
          if (st_r.tick == `DSIP_OVS_LAST) begin
            // bad stop bit drops the frame, holding latch untouched
            // a low stop bit may be taken as the next start; the mid-bit check decides
            do_latch     = st_r.sync2.sdata;
            st_nxt.rx_st = DSIP_RX_IDLE;
          end
        end
        default: st_nxt.rx_st = DSIP_RX_IDLE;
      endcase
    end

    if (do_shift) begin
      // first bit in ends up at the top; top bit falls out to the next device
      st_nxt.shift = {st_r.shift[14:0], st_r.sync2.sdata};
    end
    st_nxt.sdout = st_nxt.shift[15];

    if (do_latch) begin
      // holding latch drives the converter code straight: 0000 low end, FFFF fs-1lsb
      st_nxt.hold      = st_r.shift;
      st_nxt.pend      = 1'b1;
      st_nxt.pend_word = st_r.shift;
    end else if (st_r.pend && in_ready) begin
      st_nxt.pend = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // word stream; a full fifo holds the pending word, a newer latch replaces it
  // ----------------------------------------------------------------
  dsip_fifo #(
    .W (WORD_BITS),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (st_r.pend),
    .i_in_data   (st_r.pend_word),
    .o_in_ready  (in_ready),
    .o_out_valid (o_word_valid),
    .o_out_data  (o_word_data),
    .i_out_ready (i_word_ready)
  );

  assign o_sdout      = st_r.sdout;
  assign o_dac_code   = st_r.hold;
  assign o_async_mode = st_r.async_mode;
endmodule

// ---- tb/dsip_assertions.sv ----
// port checker of the dac serial input port
`timescale 1ns/1ps
module dsip_checker #(
  parameter int WORD_BITS  = 16,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_sclk,
  input wire logic        i_sdata,
  input wire logic        i_latch,
  input wire logic        o_sdout,
  input wire logic [15:0] o_dac_code,
  input wire logic        o_async_mode,
  input wire logic        o_word_valid,
  input wire logic [15:0] o_word_data,
  input wire logic        i_word_ready
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  mode_hold_a: assert property (o_async_mode |=> o_async_mode) else $error("mode lost");
  latch_cause_a: assert property ($changed(o_dac_code) && !o_async_mode |->
    $past(i_latch, 3)) else $error("code moved without strobe");
  code_quiet_a: assert property ((!o_async_mode && !i_latch) [*6] |=>
    $stable(o_dac_code)) else $error("code moved while strobe low");
  shift_cause_a: assert property ($changed(o_sdout) |-> $past(i_sclk, 3))
    else $error("shift without clock");
  shift_quiet_a: assert property (!i_sclk [*6] |=> $stable(o_sdout))
    else $error("shift while clock idle");
  frame_stop_a: assert property (o_async_mode && $changed(o_dac_code) |->
    $past(i_sdata, 4)) else $error("frame latched without stop");
  word_hold_a: assert property (o_word_valid && !i_word_ready |=>
    o_word_valid && $stable(o_word_data)) else $error("word dropped");
  word_match_a: assert property ($changed(o_dac_code) && !o_word_valid |->
    ##[1:6] (o_word_valid && o_word_data == o_dac_code)) else $error("word lost");
  cover property (o_async_mode && $changed(o_dac_code));
  cover property (!o_async_mode && $changed(o_dac_code));
  cover property ((o_word_valid && !i_word_ready) [*8]);
endmodule

bind dsip_top dsip_checker #(.WORD_BITS(WORD_BITS), .FIFO_DEPTH(FIFO_DEPTH)) chk (.*);

// ---- tb/dsip_host_model.sv ----
// host side of the serial link: three-wire words and framed async words
`timescale 1ns/1ps
module dsip_host_model (
  input  wire logic i_clk,
  input  wire logic i_sdout,
  output logic      o_sclk,
  output logic      o_sdata,
  output logic      o_latch
);
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b1;
    o_latch = 1'b0;
  end
  // link clock only runs inside transfers
  task automatic tick(input int h);
    o_sclk <= 1'b1;
    repeat (h) @(posedge i_clk);
    o_sclk <= 1'b0;
    repeat (h) @(posedge i_clk);
  endtask
  task automatic send_word(input logic [31:0] w, input int n, output logic [15:0] out);
    o_latch <= 1'b0;
    repeat (8) @(posedge i_clk);
    for (int i = n - 1; i >= 0; i--) begin
      o_sdata <= w[i];
      repeat (4) @(posedge i_clk);
      out = {out[14:0], i_sdout};
      tick(16);
    end
    o_sdata <= ~w[0];
    o_latch <= 1'b1;
    repeat (16) @(posedge i_clk);
  endtask
  task automatic send_frame(input logic [15:0] w, input logic stop);
    logic [17:0] f;
    f = {1'b0, w, stop};
    for (int i = 17; i >= 0; i--) begin
      o_sdata <= f[i];
      repeat (16) tick(53); // 424 ns tick keeps under 2.4 MHz
    end
    o_sdata <= 1'b1;
  endtask
  // short low pulse on an idle line must not start a frame
  task automatic glitch_start();
    o_sdata <= 1'b0;
    repeat (4) tick(53);
    o_sdata <= 1'b1;
    repeat (16) tick(53);
  endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the dac serial input port
`timescale 1ns/1ps
module tb_top;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_word_ready = 1'b0;
  logic        sclk, sdata, latch, sdout, async_mode, word_valid;
  logic [15:0] dac_code, word_data, w, seen, prev;
  logic [31:0] w32;
  logic [15:0] q[$];
  int          failures = 0;
  int          num_checks = 0;
  int          seed = 88713;

  always #2 i_clk = ~i_clk;

  dsip_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_sdata(sdata),
    .i_latch(latch), .o_sdout(sdout), .o_dac_code(dac_code), .o_async_mode(async_mode),
    .o_word_valid(word_valid), .o_word_data(word_data), .i_word_ready(i_word_ready));
  dsip_host_model host (.i_clk(i_clk), .i_sdout(sdout), .o_sclk(sclk), .o_sdata(sdata),
    .o_latch(latch));

  function automatic logic [15:0] far_part(input logic [31:0] s);
    return s[31:16];
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // mode strap is taken shortly after release, so the strobe level is set during reset
  task automatic do_reset(input logic strap);
    host.o_latch <= strap;
    i_reset_n <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (16) @(posedge i_clk);
    check("mode", {15'h0000, strap}, {15'h0000, async_mode});
  endtask
  task automatic pop(input logic [15:0] exp);
    int n;
    n = 0;
    while (word_valid !== 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    check("word valid", 16'h0001, {15'h0000, word_valid});
    check("word", exp, word_data);
    @(posedge i_clk);
    i_word_ready <= 1'b1;
    @(posedge i_clk);
    i_word_ready <= 1'b0;
    @(posedge i_clk);
  endtask

  initial begin
    prev = 16'h0000;
    do_reset(1'b0);
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($random(seed));
      host.send_word({16'h0000, w}, 16, seen);
      check("dac", w, dac_code);
      check("sdout", prev, seen);
      pop(w);
      prev = w;
    end
    $display("test corners done");
    w32 = 32'($random(seed));
    host.send_word(w32, 32, seen);
    check("dac", w32[15:0], dac_code);
    check("far", far_part(w32), seen);
    pop(w32[15:0]);
    $display("test chain done");
    // fifo plus output stage hold 17; the 18th waits as the pending word
    for (int i = 0; i < 18; i++) begin
      q.push_back(16'($random(seed)));
      host.send_word({16'h0000, q[i]}, 16, seen);
    end
    while (q.size() > 0) begin
      pop(q.pop_front());
    end
    $display("test fifo done");
    do_reset(1'b1);
    host.glitch_start();
    check("glitch", 16'h0000, dac_code);
    w = 16'($random(seed));
    host.send_frame(w, 1'b1);
    check("async dac", w, dac_code);
    pop(w);
    host.send_frame(~w, 1'b0);
    check("bad stop", w, dac_code);
    check("bad stop word", 16'h0000, {15'h0000, word_valid});
    $display("test async done");
    conclude();
  end

  initial begin
    repeat (100000) @(posedge i_clk);
    failures++;
    conclude();
  end
endmodule
